// ==== hw/ueprp_pkg.sv ====
// constants for the eprom read and program controller
package ueprp_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int CLK_MHZ = 250;
	// pin timing in nanoseconds, least times round up
	localparam int T_SETUP_NS = 2000;
	localparam int T_HOLD_NS = 2000;
	localparam int T_SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int T_HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	// read access time, least times round up
	localparam int T_ACC_NS = 150;
	localparam int T_ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	// program pulse, microseconds: nominal 1 ms within 0.95 to 1.05 ms
	localparam int T_PW_US = 1000;
	localparam int T_PW_CYC = T_PW_US * CLK_MHZ;
	// extra pulse: three times the pulse count, in ms, 2.85 to 78.75 ms
	localparam int OVER_MULT = 3;
	localparam int MAX_PULSES = 25;
	localparam logic [DATA_W-1:0] ERASED = 8'hff;
endpackage

// ==== hw/ueprp_sync.sv ====
// three stage input synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module ueprp_sync #(
	parameter int W = 8
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	// a bit changes only once stages two and three agree
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			sync_out <= '0;
		end
		else
		begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < W; i++)
			begin
				if (s2[i] == s3[i])
				begin
					sync_out[i] <= s3[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/ueprp_ctrl.sv ====
// host side controller that reads and programs the eprom over its pins
// How it works
// - enter programming only by raising supply with chip select low.
// - address and data stand before the strobe falls.
// - each normal strobe pulse is held low for one millisecond.
// - after verify, one extra pulse of three ms per pulse used.
// - between one and twenty-five normal pulses per byte.
// - never switch supply while chip select and strobe are both low.
// - main supply on first, off last, relative to programming supply.
`timescale 1ns/1ps
`default_nettype none
module ueprp_ctrl #(
	parameter int PW_CYC = ueprp_pkg::T_PW_CYC,
	parameter int MAXP = ueprp_pkg::MAX_PULSES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ueprp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [ueprp_pkg::DATA_W-1:0] req_data,
	output logic req_ready,
	output logic done,
	output logic fail,
	output logic [ueprp_pkg::DATA_W-1:0] rd_data,
	output logic [ueprp_pkg::ADDR_W-1:0] address_lines,
	output logic chip_select_n,
	output logic output_gate_n,
	output logic program_strobe_n,
	output logic main_supply_on,
	output logic prog_supply_high,
	input wire logic [ueprp_pkg::DATA_W-1:0] data_pins_in,
	output logic [ueprp_pkg::DATA_W-1:0] data_pins_out,
	output logic data_pins_oe
);
	// pulse counter is five bits wide, so the limit stays small
	if (PW_CYC < 1 || MAXP < 1 || MAXP > ueprp_pkg::MAX_PULSES)
	begin : g_bad_param
		$error("bad timing parameters");
	end

	// ****************
	// state
	// ****************
	typedef enum {S_IDLE, S_RD_ACC, S_PWR_UP, S_SETUP, S_PULSE, S_HOLD,
		S_VERIFY, S_OVER, S_OVER_HOLD, S_PWR_DN, S_REPLY} ueprp_state_t;
	typedef struct packed {
		ueprp_state_t st;
		logic [31:0] cnt;
		logic [4:0] pulses;
		logic over;
		logic ok;
		logic wr;
		logic [ueprp_pkg::DATA_W-1:0] wdata;
		logic req_ready;
		logic done;
		logic fail;
		logic [ueprp_pkg::DATA_W-1:0] rd_data;
		logic [ueprp_pkg::ADDR_W-1:0] addr;
		logic cs_n;
		logic oe_n;
		logic pgm_n;
		logic vcc;
		logic vpp;
		logic [ueprp_pkg::DATA_W-1:0] dout;
		logic doe;
	} ueprp_regs_t;
	ueprp_regs_t r;
	ueprp_regs_t next_r;
	logic [ueprp_pkg::DATA_W-1:0] din;

	ueprp_sync #(.W(ueprp_pkg::DATA_W)) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.async_in(data_pins_in),
		.sync_out(din)
	);

	// read settle covers access plus three sync stages and the agree stage
	localparam int RD_WAIT = ueprp_pkg::T_ACC_CYC + 4;

	// ****************
	// next state
	// ****************
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.cnt = r.cnt + 32'h1;
		case (r.st)
			S_IDLE:
			begin
				next_r.cnt = '0;
				next_r.cs_n = 1'b1;
				next_r.oe_n = 1'b1;
				next_r.pgm_n = 1'b1;
				next_r.doe = 1'b0;
				if (req_valid && r.req_ready)
				begin
					next_r.req_ready = 1'b0;
					next_r.addr = req_addr;
					next_r.wdata = req_data;
					next_r.wr = req_write;
					next_r.pulses = '0;
					next_r.over = 1'b0;
					next_r.fail = 1'b0;
					if (req_write)
					begin
						next_r.vcc = 1'b1;
						next_r.st = S_PWR_UP;
					end
					else
					begin
						// select and gate low to read
						next_r.cs_n = 1'b0;
						next_r.oe_n = 1'b0;
						next_r.st = S_RD_ACC;
					end
				end
			end
			S_RD_ACC:
			begin
				if (r.cnt >= 32'(RD_WAIT))
				begin
					next_r.rd_data = din;
					if (r.wr)
					begin
						next_r.oe_n = 1'b1;
						next_r.cs_n = 1'b1;
						next_r.cnt = '0;
						// done only when every bit read equals the bit wanted
						next_r.ok = ((din ^ r.wdata) == '0);
						next_r.st = S_VERIFY;
					end
					else
					begin
						next_r.st = S_REPLY;
					end
				end
			end
			S_PWR_UP:
			begin
				// raise supply while chip select is low
				if (r.cnt == 32'(ueprp_pkg::T_SETUP_CYC))
				begin
					next_r.cs_n = 1'b0;
				end
				if (r.cnt == 32'(2 * ueprp_pkg::T_SETUP_CYC))
				begin
					next_r.vpp = 1'b1;
				end
				if (r.cnt >= 32'(3 * ueprp_pkg::T_SETUP_CYC))
				begin
					next_r.cnt = '0;
					next_r.st = S_SETUP;
				end
			end
			S_SETUP:
			begin
				// drive data pins; address and data before strobe
				next_r.cs_n = 1'b0;
				next_r.oe_n = 1'b1;
				next_r.dout = r.wdata;
				next_r.doe = 1'b1;
				if (r.cnt >= 32'(ueprp_pkg::T_SETUP_CYC))
				begin
					next_r.pgm_n = 1'b0;
					next_r.cnt = '0;
					next_r.st = r.over ? S_OVER : S_PULSE;
				end
			end
			S_PULSE:
			begin
				if (r.cnt >= 32'(PW_CYC - 1))
				begin
					next_r.pgm_n = 1'b1;
					next_r.pulses = r.pulses + 5'h1;
					next_r.cnt = '0;
					next_r.st = S_HOLD;
				end
			end
			S_OVER:
			begin
				// extra pulse three ms per normal pulse used
				if (r.cnt >= 32'(PW_CYC) * 32'(ueprp_pkg::OVER_MULT) * 32'(r.pulses) - 32'h1)
				begin
					next_r.pgm_n = 1'b1;
					next_r.cnt = '0;
					next_r.st = S_OVER_HOLD;
				end
			end
			S_HOLD, S_OVER_HOLD:
			begin
				if (r.cnt >= 32'(ueprp_pkg::T_HOLD_CYC))
				begin
					next_r.doe = 1'b0;
					next_r.cnt = '0;
					if (r.st == S_OVER_HOLD)
					begin
						next_r.ok = 1'b1;
						next_r.st = S_PWR_DN;
					end
					else
					begin
						next_r.oe_n = 1'b0;
						next_r.st = S_RD_ACC;
					end
				end
			end
			S_VERIFY:
			begin
				next_r.cnt = '0;
				// repeat, extra pulse, or give up; limit
				if (r.ok)
				begin
					next_r.over = 1'b1;
					next_r.st = S_SETUP;
				end
				else if (r.pulses >= 5'(MAXP))
				begin
					next_r.fail = 1'b1;
					next_r.st = S_PWR_DN;
				end
				else
				begin
					next_r.st = S_SETUP;
				end
			end
			S_PWR_DN:
			begin
				// strobe is high before supply moves; select high
				next_r.cs_n = 1'b1;
				next_r.pgm_n = 1'b1;
				next_r.oe_n = 1'b1;
				next_r.doe = 1'b0;
				next_r.vpp = 1'b0;
				// main supply off after programming supply
				if (r.cnt >= 32'(ueprp_pkg::T_SETUP_CYC))
				begin
					next_r.vcc = 1'b0;
					next_r.st = S_REPLY;
				end
			end
			S_REPLY:
			begin
				next_r.cs_n = 1'b1;
				next_r.oe_n = 1'b1;
				next_r.done = 1'b1;
				next_r.req_ready = 1'b1;
				next_r.st = S_IDLE;
			end
			default:
			begin
				next_r.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			r <= '{st: S_IDLE, cnt: '0, pulses: '0, over: 1'b0, ok: 1'b0, wr: 1'b0,
				wdata: '0, req_ready: 1'b1, done: 1'b0, fail: 1'b0,
				rd_data: ueprp_pkg::ERASED, addr: '0, cs_n: 1'b1, oe_n: 1'b1,
				pgm_n: 1'b1, vcc: 1'b0, vpp: 1'b0, dout: '0, doe: 1'b0};
		end
		else
		begin
			r <= next_r;
		end
	end

	assign req_ready = r.req_ready;
	assign done = r.done;
	assign fail = r.fail;
	assign rd_data = r.rd_data;
	assign address_lines = r.addr;
	assign chip_select_n = r.cs_n;
	assign output_gate_n = r.oe_n;
	assign program_strobe_n = r.pgm_n;
	assign main_supply_on = r.vcc;
	assign prog_supply_high = r.vpp;
	assign data_pins_out = r.dout;
	assign data_pins_oe = r.doe;
endmodule
`default_nettype wire

// ==== verification/ueprp_dev_model.sv ====
// behavioural model of the 8k by 8 eprom at the far side
`timescale 1ns/1ps
`default_nettype none
// ****
// device model
// ****
module ueprp_dev_model (
	input wire logic [ueprp_pkg::ADDR_W-1:0] address_lines,
	input wire logic chip_select_n,
	input wire logic output_gate_n,
	input wire logic program_strobe_n,
	input wire logic prog_supply_high,
	input wire logic [ueprp_pkg::DATA_W-1:0] data_in,
	input var int need,
	output logic [ueprp_pkg::DATA_W-1:0] data_out,
	output logic drive,
	output var int pulses
);
	logic [ueprp_pkg::DATA_W-1:0] mem [1 << ueprp_pkg::ADDR_W] = '{default: 8'hff};
	bit vpp_was;
	// program on strobe end
	// weak cells need several pulses; select may toggle between pulses
	always @(posedge program_strobe_n or posedge prog_supply_high or negedge prog_supply_high)
	begin
		if (prog_supply_high && !vpp_was)
		begin
			pulses = 0;
		end
		else if (prog_supply_high && !chip_select_n && output_gate_n)
		begin
			pulses++;
			if (pulses >= need)
				mem[address_lines] &= data_in;
		end
		vpp_was = prog_supply_high;
	end
	assign drive = !chip_select_n && !output_gate_n && program_strobe_n;
	assign data_out = mem[address_lines];
endmodule
`default_nettype wire

// ==== verification/ueprp_ctrl_checker.sv ====
// assertion checker for the eprom controller pins
`timescale 1ns/1ps
`default_nettype none
// ****
// pin checks
// ****
module ueprp_ctrl_checker #(
	parameter int PW_CYC = 20
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [ueprp_pkg::ADDR_W-1:0] address_lines,
	input wire logic chip_select_n,
	input wire logic output_gate_n,
	input wire logic program_strobe_n,
	input wire logic main_supply_on,
	input wire logic prog_supply_high,
	input wire logic [ueprp_pkg::DATA_W-1:0] data_pins_out,
	input wire logic data_pins_oe
);
	int low_cnt;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clock)
		low_cnt <= program_strobe_n ? 0 : low_cnt + 1;
	property p_gate;
		!output_gate_n |-> !chip_select_n && program_strobe_n && !data_pins_oe;
	endproperty
	a_gate: assert property (p_gate) else $error("gate low off read");
	property p_idle;
		chip_select_n |-> program_strobe_n && !data_pins_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("activity unselected");
	property p_prog;
		!program_strobe_n |-> prog_supply_high && output_gate_n && data_pins_oe;
	endproperty
	a_prog: assert property (p_prog) else $error("strobe off program mode");
	property p_entry;
		$rose(prog_supply_high) |-> !chip_select_n && main_supply_on;
	endproperty
	a_entry: assert property (p_entry) else $error("bad program entry");
	property p_setup;
		!program_strobe_n |-> $stable(data_pins_out) && $stable(address_lines);
	endproperty
	a_setup: assert property (p_setup) else $error("pins moved in pulse");
	property p_width;
		$rose(program_strobe_n) |-> low_cnt == PW_CYC || low_cnt % (3 * PW_CYC) == 0;
	endproperty
	a_width: assert property (p_width) else $error("pulse width");
	property p_hold;
		!chip_select_n && !program_strobe_n |-> $stable(prog_supply_high);
	endproperty
	a_hold: assert property (p_hold) else $error("supply moved in pulse");
	property p_vcc;
		!main_supply_on |-> !prog_supply_high;
	endproperty
	a_vcc: assert property (p_vcc) else $error("supply order");
endmodule
bind ueprp_ctrl ueprp_ctrl_checker #(.PW_CYC(PW_CYC)) ueprp_ctrl_checker_i (
	.clock(clock), .sys_rst(sys_rst), .address_lines(address_lines),
	.chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
	.program_strobe_n(program_strobe_n), .main_supply_on(main_supply_on),
	.prog_supply_high(prog_supply_high), .data_pins_out(data_pins_out),
	.data_pins_oe(data_pins_oe));
`default_nettype wire

// ==== verification/tb_uv_eprom_read_program_port.sv ====
// testbench for the eprom read and program controller
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb_uv_eprom_read_program_port;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [12:0] req_addr = 13'h0000;
	logic [7:0] req_data = 8'h00;
	logic req_ready, done, fail, cs_n, oe_n, pgm_n, vcc, vpp, pins_oe, dev_drive;
	logic [12:0] addr;
	logic [7:0] rd_data, pins_in, pins_out, dev_q;
	int need = 1;
	int pulses;
	int err_total = 0;
	int checks_done = 0;
	always #2 clock = ~clock;
	// released pins show the inverse, not a held value
	assign pins_in = pins_oe ? pins_out : dev_drive ? dev_q : ~dev_q;
	ueprp_ctrl #(.PW_CYC(20), .MAXP(4)) ueprp_ctrl_i (.clock(clock), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_data(req_data), .req_ready(req_ready), .done(done), .fail(fail),
		.rd_data(rd_data), .address_lines(addr), .chip_select_n(cs_n),
		.output_gate_n(oe_n), .program_strobe_n(pgm_n), .main_supply_on(vcc),
		.prog_supply_high(vpp), .data_pins_in(pins_in), .data_pins_out(pins_out),
		.data_pins_oe(pins_oe));
	ueprp_dev_model ueprp_dev_model_i (.address_lines(addr), .chip_select_n(cs_n),
		.output_gate_n(oe_n), .program_strobe_n(pgm_n), .prog_supply_high(vpp),
		.data_in(pins_in), .need(need), .data_out(dev_q), .drive(dev_drive),
		.pulses(pulses));
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// drives on a rising edge, returns one ns after the done edge
	task automatic req(input logic w, input logic [12:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_data <= d;
		@(posedge clock);
		req_valid <= 1'b0;
		for (n = 0; n < 30000; n++)
		begin
			@(posedge clock);
			#1;
			if (n == 0)
				chk("busy", req_ready, 16'h0000);
			if (done === 1'b1)
				break;
		end
		if (n == 30000)
		begin
			err_total++;
			close_out;
		end
		else
		begin
			chk("ready", req_ready, 16'h0001);
		end
	endtask
	task automatic t_blank;
		req(1'b0, 13'h1fff, 8'h00);
		chk("blank", rd_data, 16'h00ff);
		chk("float", dev_drive, 16'h0000);
		chk("released", {cs_n, oe_n, pins_oe}, 16'h0006);
	endtask
	task automatic t_prog_one;
		req(1'b1, 13'h0005, 8'h5a);
		chk("fail1", fail, 16'h0000);
		chk("pulses1", pulses[15:0], 16'h0002);
		chk("supply1", {vcc, vpp}, 16'h0000);
		req(1'b0, 13'h0005, 8'h00);
		chk("read1", rd_data, 16'h005a);
	endtask
	task automatic t_prog_retry;
		need = 3;
		req(1'b1, 13'h0000, 8'h00);
		chk("fail3", fail, 16'h0000);
		chk("pulses3", pulses[15:0], 16'h0004);
		req(1'b0, 13'h0000, 8'h00);
		chk("read3", rd_data, 16'h0000);
	endtask
	task automatic t_prog_refuse;
		need = 1;
		req(1'b1, 13'h0005, 8'hff);
		chk("failx", fail, 16'h0001);
		chk("pulsesx", pulses[15:0], 16'h0004);
		req(1'b0, 13'h0005, 8'h00);
		chk("readx", rd_data, 16'h005a);
		chk("failclr", fail, 16'h0000);
	endtask
	// reset in mid power-up, before the supply is raised
	task automatic t_reset;
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= 1'b1;
		req_addr <= 13'h0007;
		req_data <= 8'h00;
		@(posedge clock);
		req_valid <= 1'b0;
		repeat (700) @(posedge clock);
		sys_rst <= 1'b1;
		#1;
		chk("midcs", {cs_n, vcc, vpp}, 16'h0002);
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		chk("rstready", req_ready, 16'h0001);
		chk("rstpins", {cs_n, oe_n, pgm_n, pins_oe}, 16'h000e);
		chk("rstsupply", {vcc, vpp}, 16'h0000);
		chk("rstdata", rd_data, 16'h00ff);
		req(1'b0, 13'h0005, 8'h00);
		chk("rstread", rd_data, 16'h005a);
	endtask
	initial
	begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		t_prog_one;
		t_blank;
		t_prog_retry;
		t_prog_refuse;
		t_reset;
		close_out;
	end
endmodule
`default_nettype wire
